// ===== tb/jtag_host_model.sv
// Purpose: Scan host driving the test access port
// Assumes: Single device in the scan chain
// Notes:   Test clock pulses only inside frames, idle low between them
`timescale 1ns/1ps

module jtag_host_model (
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out,
  input  wire logic tdo_in
);
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end

  // One test clock of 125 ns; mode and data change while the clock is low
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_out = tms;
    tdi_out = tdi;
    #62.5;
    tdo = tdo_in;
    tck_out = 1'b1;
    #62.5;
    tck_out = 1'b0;
  endtask

  task automatic tap_reset;
    logic d;
    repeat (5) step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask

  // Idle to Pause; stopping there lets the bench look before Update
  task automatic scan(input logic is_ir, input int n, input logic [1031:0] din,
                      output logic [1031:0] dout);
    logic d;
    dout = 1032'h0;
    step(1'b1, 1'b0, d);
    if (is_ir) step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], d);
      dout[i] = d;
    end
    step(1'b0, 1'b0, d);
  endtask

  // Pause, Exit2, Update, then straight to Idle for the execute clock
  task automatic finish;
    logic d;
    step(1'b1, 1'b0, d);
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask

  // Page chains used freely: this host sees the device first in chain
  task automatic load_ir(input logic [3:0] code);
    logic [1031:0] q;
    scan(1'b1, 4, {1028'h0, code}, q);
    finish();
  endtask
endmodule

// ===== tb/jtag_prog_sva.sv
// Purpose: Assertions on the chip-side ports of the programming registers
// Assumes: Time-out parameters equal those of the bound instance
// Notes:   Chip clock domain only
`timescale 1ns/1ps
`include "jtag_prog_consts.svh"

module jtag_prog_sva #(
  parameter int TOUT_SHORT_CYC = 20,
  parameter int TOUT_LONG_CYC  = 50
) (
  input wire logic                   clk_in,
  input wire logic                   arst_n_in,
  input wire logic [`CMD_W-1:0]      cmd_word_out,
  input wire logic                   cmd_strobe_out,
  input wire logic                   exec_out,
  input wire logic                   pb_we_out,
  input wire logic [`PAGE_IDX_W-1:0] pb_addr_out,
  input wire logic [`PAGE_IDX_W-1:0] rd_addr_out,
  input wire logic                   part_reset_out,
  input wire logic                   prog_mode_out
);
  // ----------------------------------------
  // Reset high-time counter
  // ----------------------------------------
  logic [31:0] hi_cnt_ff;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hi_cnt_ff <= 32'h0;
    end else begin
      hi_cnt_ff <= part_reset_out ? hi_cnt_ff + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  strobe_pulse_a: assert property (cmd_strobe_out |=> !cmd_strobe_out)
    else $error("command strobe longer than one cycle");
  cmd_change_a: assert property ($changed(cmd_word_out) |-> cmd_strobe_out)
    else $error("command word changed without strobe");
  strobe_lock_a: assert property (cmd_strobe_out |-> prog_mode_out)
    else $error("command applied while locked");
  exec_once_a: assert property (exec_out |=> !exec_out ##1 !exec_out)
    else $error("execute clock longer than one cycle");
  exec_lock_a: assert property (exec_out |-> prog_mode_out)
    else $error("execute clock while locked");
  byte_space_a: assert property (pb_we_out |=> !pb_we_out [*8])
    else $error("page writes closer than one byte");
  load_lock_a: assert property (pb_we_out |-> prog_mode_out)
    else $error("page write while locked");
  load_step_a: assert property ($changed(pb_addr_out) |->
    pb_addr_out == $past(pb_addr_out) + 7'h1 || pb_addr_out == 7'h0)
    else $error("page write index skipped");
  read_step_a: assert property ($changed(rd_addr_out) |->
    rd_addr_out == $past(rd_addr_out) + 7'h1 || rd_addr_out == 7'h0)
    else $error("page read index skipped");
  reset_hold_a: assert property ($fell(part_reset_out) |-> hi_cnt_ff >= TOUT_SHORT_CYC)
    else $error("part reset released before time-out");
endmodule

bind jtag_programming_data_regs jtag_prog_sva #(
  .TOUT_SHORT_CYC(TOUT_SHORT_CYC),
  .TOUT_LONG_CYC (TOUT_LONG_CYC)
) chk_u (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .cmd_word_out(cmd_word_out),
  .cmd_strobe_out(cmd_strobe_out), .exec_out(exec_out), .pb_we_out(pb_we_out),
  .pb_addr_out(pb_addr_out), .rd_addr_out(rd_addr_out),
  .part_reset_out(part_reset_out), .prog_mode_out(prog_mode_out)
);

// ===== tb/jtag_programming_data_regs_tb.sv
// Purpose: Self-checking bench of the programming data registers
// Assumes: Time-outs shortened to 20 and 50 chip clocks
// Notes:   Host model drives the scan port, bench models the flash
`timescale 1ns/1ps
`include "jtag_prog_consts.svh"

module jtag_programming_data_regs_tb;
  import jtag_prog_pkg::*;
  localparam int TS = 20;
  localparam int TL = 50;
  logic                   clk_in, arst_n_in, tck, tms, tdi, tdo, tdo_oe;
  logic                   long_tout_fuse_in, cmd_strobe_out, exec_out, pb_we_out;
  logic                   part_reset_out, prog_mode_out;
  logic [`CMD_W-1:0]      result_in, cmd_word_out;
  logic [`BYTE_W-1:0]     rd_data_in = 8'h0;
  logic [`BYTE_W-1:0]     pb_data_out;
  logic [`PAGE_IDX_W-1:0] pb_addr_out, rd_addr_out;
  logic [`BYTE_W-1:0]     pb_mem [128];
  logic [`CMD_W-1:0]      res_tab [2] = '{15'h2b6d, 15'h50f3};
  logic [`CMD_W-1:0]      cmd_tab [2] = '{15'h1e35, 15'h4a1c};
  int                     mismatches, check_count, exec_n, strobe_n, pb_n;

  jtag_programming_data_regs #(.TOUT_SHORT_CYC(TS), .TOUT_LONG_CYC(TL)) dut_u (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
    .long_tout_fuse_in(long_tout_fuse_in), .result_in(result_in),
    .rd_data_in(rd_data_in), .cmd_word_out(cmd_word_out),
    .cmd_strobe_out(cmd_strobe_out), .exec_out(exec_out), .pb_we_out(pb_we_out),
    .pb_addr_out(pb_addr_out), .pb_data_out(pb_data_out), .rd_addr_out(rd_addr_out),
    .part_reset_out(part_reset_out), .prog_mode_out(prog_mode_out));

  jtag_host_model host_u (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Flash byte answers half a clock after its index
  always @(negedge clk_in) rd_data_in <= {1'b0, rd_addr_out} ^ 8'h3c;

  always @(posedge clk_in) begin
    if (exec_out === 1'b1) exec_n++;
    if (cmd_strobe_out === 1'b1) strobe_n++;
    if (pb_we_out === 1'b1) begin
      pb_mem[pb_addr_out] = pb_data_out;
      pb_n++;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wclk(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic unlock(input logic [15:0] sig, input logic old_pm, input logic new_pm);
    logic [1031:0] q;
    host_u.scan(1'b1, 4, {1028'h0, `IR_UNLOCK}, q);
    chk(q[3:0], `IR_CAPTURE);
    host_u.finish();
    host_u.scan(1'b0, 16, {1016'h0, sig}, q);
    wclk(8);
    chk(prog_mode_out, old_pm);
    host_u.finish();
    wclk(8);
    chk(prog_mode_out, new_pm);
    $display("unlock test done, signature %h", sig);
  endtask

  task automatic t_rst_chain(input logic fuse, input logic release_bit);
    logic [1031:0] q;
    logic pm;
    int n;
    pm = prog_mode_out;
    wclk(1);
    long_tout_fuse_in = fuse;
    host_u.load_ir(`IR_RESET_CHAIN);
    host_u.scan(1'b0, 1, 1032'h1, q);
    wclk(8);
    chk(part_reset_out, 1'b1);
    host_u.finish();
    wclk(80);
    chk(part_reset_out, 1'b1);
    if (release_bit) begin
      n = 0;
      fork
        host_u.scan(1'b0, 1, 1032'h0, q);
        begin
          repeat (4) @(posedge tck);
          while (part_reset_out === 1'b1 && n < 200) begin
            @(posedge clk_in);
            n++;
          end
        end
      join
      host_u.finish();
      chk(n >= (fuse ? TL : TS) && n <= (fuse ? TL : TS) + 6, 1'b1);
    end
    chk(prog_mode_out, pm);
    $display("reset chain test done, fuse %0d", fuse);
  endtask

  task automatic t_cmd;
    logic [1031:0] q;
    host_u.load_ir(`IR_CMD);
    for (int i = 0; i < 2; i++) begin
      wclk(1);
      result_in = res_tab[i];
      wclk(2);
      exec_n = 0;
      strobe_n = 0;
      host_u.scan(1'b0, `CMD_W, {1017'h0, cmd_tab[i]}, q);
      chk(q[14:0], res_tab[i]);
      chk(strobe_n, 0);
      host_u.finish();
      wclk(8);
      chk(cmd_word_out, cmd_tab[i]);
      chk(exec_n, 1);
    end
    $display("command test done");
  endtask

  task automatic t_load(input logic unlocked);
    logic [1031:0] d, q;
    pb_n = 0;
    for (int i = 0; i < 128; i++) d[8*i +: 8] = 8'(i) ^ 8'h96;
    host_u.load_ir(`IR_PAGE_LOAD);
    host_u.scan(1'b0, `PAGE_BITS, d, q);
    wclk(8);
    chk(pb_n, unlocked ? 128 : 0);
    host_u.finish();
    wclk(8);
    chk(pb_n, unlocked ? 128 : 0);
    for (int i = 0; i < 128 && unlocked; i++) chk(pb_mem[i], 8'(i) ^ 8'h96);
    $display("page load test done");
  endtask

  task automatic t_read;
    logic [1031:0] d, q;
    for (int i = 0; i < 1032; i++) d[i] = i[0];
    host_u.load_ir(`IR_PAGE_READ);
    fork
      host_u.scan(1'b0, `PAGE_READ_BITS, d, q);
      begin
        repeat (10) @(posedge tck);
        chk(tdo_oe, 1'b1);
      end
    join
    host_u.finish();
    chk(tdo_oe, 1'b0);
    for (int i = 0; i < 128; i++) chk(q[8*i+8 +: 8], 8'(i) ^ 8'h3c);
    $display("page read test done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    arst_n_in = 1'b0;
    result_in = 15'h0;
    long_tout_fuse_in = 1'b0;
    repeat (20) @(negedge clk_in);
    arst_n_in = 1'b1;
    wclk(2);
    chk(prog_mode_out, 1'b0);
    chk(part_reset_out, 1'b0);
    host_u.tap_reset();
    t_rst_chain(1'b0, 1'b1);
    t_rst_chain(1'b0, 1'b0);
    unlock(16'ha371, 1'b0, 1'b0);
    unlock(16'ha370, 1'b0, 1'b1);
    t_cmd();
    t_load(1'b1);
    t_read();
    t_rst_chain(1'b1, 1'b1);
    unlock(16'h0000, 1'b1, 1'b0);
    t_load(1'b0);
    stop_test();
  end

  initial begin
    #900000;
    mismatches++;
    stop_test();
  end
endmodule

// ===== verilog/jtag_prog_consts.svh
// Purpose: Constants of the JTAG programming data registers
// Assumes: Chip clock of 100 MHz
// Notes:   Definitions only
`ifndef JTAG_PROG_CONSTS_SVH
`define JTAG_PROG_CONSTS_SVH

// ----------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------
`define IR_W             4
`define IR_CAPTURE       4'h1
`define IR_RESET_VAL     4'hf
`define IR_UNLOCK        4'h4
`define IR_CMD           4'h5
`define IR_PAGE_LOAD     4'h6
`define IR_PAGE_READ     4'h7
`define IR_RESET_CHAIN   4'hc

// ----------------------------------------------------------------
// Data registers
// ----------------------------------------------------------------
`define CMD_W            15
`define UNLOCK_W         16
`define UNLOCK_SIG       16'ha370
`define BYTE_W           8
`define BIT_CNT_W        3
`define BIT_LAST         3'h7
`define PAGE_BITS        1024
`define PAGE_READ_BITS   1032
`define PAGE_IDX_W       7

// ----------------------------------------------------------------
// Clock domain crossing slots
// ----------------------------------------------------------------
`define SYNC_N           9
`define SY_UPD           0
`define SY_EXEC          1
`define SY_LD            2
`define SY_RD            3
`define SY_RST           4
`define SY_HOLD          5
`define SY_PE            6
`define SY_LDACT         7
`define SY_RDACT         8

// ----------------------------------------------------------------
// Reset time-out
// ----------------------------------------------------------------
`define CLK_MHZ          100
`define TOUT_SHORT_US    4
`define TOUT_LONG_US     65000
`define TOUT_W           23

`endif

// ===== verilog/jtag_prog_pkg.sv
// Purpose: Types of the JTAG programming data registers
// Assumes: Constants header on the include path
// Notes:   Rising-edge state of each clock domain is one packed struct
package jtag_prog_pkg;
  `include "jtag_prog_consts.svh"

  typedef enum logic [3:0] {
    TEST_RESET, RUN_IDLE,
    SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } tap_state_t;

  typedef struct packed {
    tap_state_t                 tap;
    logic [`IR_W-1:0]           ir;
    logic [`IR_W-1:0]           ir_sh;
    logic [`CMD_W-1:0]          cmd_sh;
    logic [`CMD_W-1:0]          cmd_word;
    logic [`UNLOCK_W-1:0]       unlock_sh;
    logic                       prog_en;
    logic                       rst_bit;
    logic                       bypass;
    logic [`BYTE_W-1:0]         byte_sh;
    logic [`BIT_CNT_W-1:0]      bit_cnt;
    logic [`BYTE_W-1:0]         ld_byte;
    logic                       upd_tgl;
    logic                       exec_tgl;
    logic                       ld_tgl;
    logic                       rd_tgl;
    logic                       hold;
  } tck_state_t;

  typedef struct packed {
    logic [`SYNC_N-1:0]         s1;
    logic [`SYNC_N-1:0]         s2;
    logic [`SYNC_N-1:0]         s3;
    logic [`SYNC_N-1:0]         stb;
    logic [`CMD_W-1:0]          cmd_word;
    logic                       cmd_strobe;
    logic                       exec;
    logic [`CMD_W-1:0]          res;
    logic                       pb_we;
    logic [`PAGE_IDX_W-1:0]     pb_addr;
    logic [`BYTE_W-1:0]         pb_data;
    logic [`PAGE_IDX_W-1:0]     rd_addr;
    logic                       rd_pend;
    logic [`BYTE_W-1:0]         rd_byte;
    logic                       part_rst;
    logic [`TOUT_W-1:0]         tout_cnt;
    logic                       prog_mode;
  } core_state_t;
endpackage

// ===== verilog/jtag_programming_data_regs.sv
// Purpose: TAP controller and programming data registers of the scan port
// Assumes: Test clock period of at least five chip clocks
// Notes:   Scan side runs on tck_in, flash side on clk_in
`timescale 1ns/1ps
`include "jtag_prog_consts.svh"

module jtag_programming_data_regs
  import jtag_prog_pkg::*;
#(
  parameter int TOUT_SHORT_CYC = `TOUT_SHORT_US * `CLK_MHZ,
  parameter int TOUT_LONG_CYC  = `TOUT_LONG_US * `CLK_MHZ
) (
  input  wire logic                   clk_in,
  input  wire logic                   arst_n_in,
  input  wire logic                   tck_in,
  input  wire logic                   tms_in,
  input  wire logic                   tdi_in,
  output logic                        tdo_out,
  output logic                        tdo_oe_out,
  input  wire logic                   long_tout_fuse_in,
  input  wire logic [`CMD_W-1:0]      result_in,
  input  wire logic [`BYTE_W-1:0]     rd_data_in,
  output logic [`CMD_W-1:0]           cmd_word_out,
  output logic                        cmd_strobe_out,
  output logic                        exec_out,
  output logic                        pb_we_out,
  output logic [`PAGE_IDX_W-1:0]      pb_addr_out,
  output logic [`BYTE_W-1:0]          pb_data_out,
  output logic [`PAGE_IDX_W-1:0]      rd_addr_out,
  output logic                        part_reset_out,
  output logic                        prog_mode_out
);
  import jtag_prog_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Both loads must fit the time-out counter
  if (TOUT_SHORT_CYC < 1 || TOUT_LONG_CYC < 1 ||
      TOUT_SHORT_CYC >= (1 << `TOUT_W) || TOUT_LONG_CYC >= (1 << `TOUT_W)) begin : g_chk
    $error("reset time-out count out of range");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Standard test access port sequencing
  function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
    tap_state_t n;
    n = s;
    case (s)
      TEST_RESET: n = tms ? TEST_RESET : RUN_IDLE;
      RUN_IDLE:   n = tms ? SEL_DR : RUN_IDLE;
      SEL_DR:     n = tms ? SEL_IR : CAP_DR;
      CAP_DR:     n = tms ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR:   n = tms ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR:   n = tms ? UPD_DR : PAUSE_DR;
      PAUSE_DR:   n = tms ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR:   n = tms ? UPD_DR : SHIFT_DR;
      UPD_DR:     n = tms ? SEL_DR : RUN_IDLE;
      SEL_IR:     n = tms ? TEST_RESET : CAP_IR;
      CAP_IR:     n = tms ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR:   n = tms ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR:   n = tms ? UPD_IR : PAUSE_IR;
      PAUSE_IR:   n = tms ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR:   n = tms ? UPD_IR : SHIFT_IR;
      UPD_IR:     n = tms ? SEL_DR : RUN_IDLE;
      default:    n = TEST_RESET;
    endcase
    return n;
  endfunction

  // Page instructions only act once programming is unlocked
  function automatic logic page_op(input logic [`IR_W-1:0] ir, input logic [`IR_W-1:0] code,
                                   input logic en);
    return (ir == code) && en;
  endfunction

  // ----------------------------------------------------------------
  // Scan side (test clock)
  // ----------------------------------------------------------------
  tck_state_t tck_ff;
  tck_state_t nxt_tck;
  core_state_t core_ff;
  core_state_t nxt_core;
  logic        tdo_ff;
  logic        tdo_oe_ff;
  logic        nxt_tdo;
  logic        nxt_tdo_oe;

  // One pass per test clock edge; each state owns its own stage
  always_comb begin
    nxt_tck     = tck_ff;
    nxt_tck.tap = tap_next(tck_ff.tap, tms_in);
    case (tck_ff.tap)
      TEST_RESET: begin
        nxt_tck.ir   = `IR_RESET_VAL;
        nxt_tck.hold = 1'b0;
      end
      SEL_DR: begin
        // Freezes the result word only on the way to capture;
        // an instruction scan passing through must leave it free
        nxt_tck.hold = !tms_in;
      end
      CAP_IR: begin
        nxt_tck.ir_sh = `IR_CAPTURE;
      end
      SHIFT_IR: begin
        nxt_tck.ir_sh = {tdi_in, tck_ff.ir_sh[`IR_W-1:1]};
      end
      UPD_IR: begin
        nxt_tck.ir = tck_ff.ir_sh;
      end
      CAP_DR: begin
        nxt_tck.bit_cnt = '0;
        nxt_tck.bypass  = 1'b0;
        if (tck_ff.ir == `IR_CMD) begin
          nxt_tck.cmd_sh = core_ff.res;
        end
        if (page_op(tck_ff.ir, `IR_PAGE_READ, tck_ff.prog_en)) begin
          // Shifter is left as is; only the first fetch starts
          nxt_tck.rd_tgl = ~tck_ff.rd_tgl;
        end
      end
      SHIFT_DR: begin
        if (tck_ff.ir == `IR_CMD) begin
          nxt_tck.cmd_sh = {tdi_in, tck_ff.cmd_sh[`CMD_W-1:1]};
        end else if (tck_ff.ir == `IR_UNLOCK) begin
          nxt_tck.unlock_sh = {tdi_in, tck_ff.unlock_sh[`UNLOCK_W-1:1]};
        end else if (tck_ff.ir == `IR_RESET_CHAIN) begin
          // Acts on the part at once, no update stage
          nxt_tck.rst_bit = tdi_in;
        end else if (page_op(tck_ff.ir, `IR_PAGE_LOAD, tck_ff.prog_en)) begin
          nxt_tck.byte_sh = {tdi_in, tck_ff.byte_sh[`BYTE_W-1:1]};
          nxt_tck.bit_cnt = tck_ff.bit_cnt + 1'b1;
          if (tck_ff.bit_cnt == `BIT_LAST) begin
            nxt_tck.ld_byte = {tdi_in, tck_ff.byte_sh[`BYTE_W-1:1]};
            nxt_tck.ld_tgl  = ~tck_ff.ld_tgl;
          end
        end else if (page_op(tck_ff.ir, `IR_PAGE_READ, tck_ff.prog_en)) begin
          // TDI is not looked at here
          nxt_tck.byte_sh = {1'b0, tck_ff.byte_sh[`BYTE_W-1:1]};
          nxt_tck.bit_cnt = tck_ff.bit_cnt + 1'b1;
          if (tck_ff.bit_cnt == `BIT_LAST) begin
            // Fetched byte settled long before the eighth edge
            nxt_tck.byte_sh = core_ff.rd_byte;
            nxt_tck.rd_tgl  = ~tck_ff.rd_tgl;
          end
        end else begin
          nxt_tck.bypass = tdi_in;
        end
      end
      UPD_DR: begin
        nxt_tck.hold = 1'b0;
        if (tck_ff.ir == `IR_CMD) begin
          nxt_tck.cmd_word = tck_ff.cmd_sh;
          nxt_tck.upd_tgl  = ~tck_ff.upd_tgl;
          if (!tms_in) begin
            nxt_tck.exec_tgl = ~tck_ff.exec_tgl;
          end
        end else if (tck_ff.ir == `IR_UNLOCK) begin
          nxt_tck.prog_en = (tck_ff.unlock_sh == `UNLOCK_SIG);
        end
      end
      default: begin
        nxt_tck.hold = tck_ff.hold;
      end
    endcase
  end

  // TAP and instruction survive the reset chain; power-on or the TEST_RESET state clears them
  always_ff @(posedge tck_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tck_ff     <= '0;
      tck_ff.tap <= TEST_RESET;
      tck_ff.ir  <= `IR_RESET_VAL;
    end else begin
      tck_ff <= nxt_tck;
    end
  end

  // ----------------------------------------------------------------
  // Test data out, changed on the falling test clock edge
  // ----------------------------------------------------------------
  always_comb begin
    nxt_tdo    = 1'b0;
    nxt_tdo_oe = (tck_ff.tap == SHIFT_DR) || (tck_ff.tap == SHIFT_IR);
    if (tck_ff.tap == SHIFT_IR) begin
      nxt_tdo = tck_ff.ir_sh[0];
    end else if (tck_ff.ir == `IR_CMD) begin
      nxt_tdo = tck_ff.cmd_sh[0];
    end else if (tck_ff.ir == `IR_UNLOCK) begin
      nxt_tdo = tck_ff.unlock_sh[0];
    end else if (tck_ff.ir == `IR_RESET_CHAIN) begin
      nxt_tdo = tck_ff.rst_bit;
    end else if (page_op(tck_ff.ir, `IR_PAGE_LOAD, tck_ff.prog_en) ||
                 page_op(tck_ff.ir, `IR_PAGE_READ, tck_ff.prog_en)) begin
      nxt_tdo = tck_ff.byte_sh[0];
    end else begin
      nxt_tdo = tck_ff.bypass;
    end
  end

  // Falling edge gives the host half a period to sample
  always_ff @(negedge tck_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tdo_ff    <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      tdo_ff    <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
    end
  end

  // ----------------------------------------------------------------
  // Flash side (chip clock)
  // ----------------------------------------------------------------
  logic [`SYNC_N-1:0] cross_in;
  logic [`SYNC_N-1:0] stable;
  logic [`SYNC_N-1:0] event_v;

  always_comb begin
    cross_in              = '0;
    cross_in[`SY_UPD]     = tck_ff.upd_tgl;
    cross_in[`SY_EXEC]    = tck_ff.exec_tgl;
    cross_in[`SY_LD]      = tck_ff.ld_tgl;
    cross_in[`SY_RD]      = tck_ff.rd_tgl;
    cross_in[`SY_RST]     = tck_ff.rst_bit;
    cross_in[`SY_HOLD]    = tck_ff.hold;
    cross_in[`SY_PE]      = tck_ff.prog_en;
    cross_in[`SY_LDACT]   = (tck_ff.ir == `IR_PAGE_LOAD);
    cross_in[`SY_RDACT]   = (tck_ff.ir == `IR_PAGE_READ);
    // A change counts once the second and third stages agree
    stable  = (~(core_ff.s2 ^ core_ff.s3) & core_ff.s3) |
              ((core_ff.s2 ^ core_ff.s3) & core_ff.stb);
    event_v = stable ^ core_ff.stb;
  end

  always_comb begin
    nxt_core            = core_ff;
    nxt_core.s1         = cross_in;
    nxt_core.s2         = core_ff.s1;
    nxt_core.s3         = core_ff.s2;
    nxt_core.stb        = stable;
    nxt_core.cmd_strobe = 1'b0;
    nxt_core.exec       = 1'b0;
    nxt_core.pb_we      = 1'b0;
    nxt_core.prog_mode  = stable[`SY_PE];
    // Result word only moves while no data scan is under way
    if (!stable[`SY_HOLD]) begin
      nxt_core.res = result_in;
    end
    // Word is steady for a whole scan once its toggle has crossed
    if (event_v[`SY_UPD] && stable[`SY_PE]) begin
      nxt_core.cmd_word   = tck_ff.cmd_word;
      nxt_core.cmd_strobe = 1'b1;
    end
    if (event_v[`SY_EXEC] && stable[`SY_PE]) begin
      nxt_core.exec = 1'b1;
    end
    // Page index restarts whenever the chain is deselected
    if (!stable[`SY_LDACT]) begin
      nxt_core.pb_addr = '0;
    end else if (core_ff.pb_we) begin
      nxt_core.pb_addr = core_ff.pb_addr + 1'b1;
    end
    if (event_v[`SY_LD]) begin
      nxt_core.pb_we   = 1'b1;
      nxt_core.pb_data = tck_ff.ld_byte;
    end
    if (!stable[`SY_RDACT]) begin
      nxt_core.rd_addr = '0;
      nxt_core.rd_pend = 1'b0;
    end else if (event_v[`SY_RD]) begin
      nxt_core.rd_pend = 1'b1;
    end else if (core_ff.rd_pend) begin
      // Flash answers one clock after the address
      nxt_core.rd_byte = rd_data_in;
      nxt_core.rd_addr = core_ff.rd_addr + 1'b1;
      nxt_core.rd_pend = 1'b0;
    end
    // Reload keeps the count full while the bit is held
    if (stable[`SY_RST]) begin
      nxt_core.part_rst = 1'b1;
      nxt_core.tout_cnt = long_tout_fuse_in ? `TOUT_W'(TOUT_LONG_CYC)
                                            : `TOUT_W'(TOUT_SHORT_CYC);
    end else if (core_ff.tout_cnt != '0) begin
      nxt_core.tout_cnt = core_ff.tout_cnt - 1'b1;
      nxt_core.part_rst = 1'b1;
    end else begin
      nxt_core.part_rst = 1'b0;
    end
  end

  // Power-on clears all chip-side state, the lock included
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      core_ff <= '0;
    end else begin
      core_ff <= nxt_core;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a bit of registered state
  assign tdo_out        = tdo_ff;
  assign tdo_oe_out     = tdo_oe_ff;
  assign cmd_word_out   = core_ff.cmd_word;
  assign cmd_strobe_out = core_ff.cmd_strobe;
  assign exec_out       = core_ff.exec;
  assign pb_we_out      = core_ff.pb_we;
  assign pb_addr_out    = core_ff.pb_addr;
  assign pb_data_out    = core_ff.pb_data;
  assign rd_addr_out    = core_ff.rd_addr;
  assign part_reset_out = core_ff.part_rst;
  assign prog_mode_out  = core_ff.prog_mode;

endmodule
